// ===== hw/s2tc_top.sv
// Translation control register bank: stage 2 control, domains, top-level base and control.
//
// Overview of operation
// - Stage 2 size code picks 32/36/40 bits.
// - Stage 2 granule: 00 4KB, 01 64KB.
// - Shareability code: none, reserved, outer, inner.
// - Outer cacheability code sets walk attributes.
// - Inner cacheability code sets walk attributes.
// - Stage 2 holds two-bit starting level.
// - Size offset gives region two^(64-offset).
// - Stage 2 fields may be cached; invalidate.
// - Domain code 00 faults in 32-bit state.
// - Client domain checks table permissions.
// - Manager domain skips table permissions.
// - Domain register inert in wide state.
// - Base register: 48-bit base, top zero.
// - Walker treats low base bits as zero.
// - Low base bits read back as written.
// - Top-byte bit drops address top byte.
// - Top-level size code picks 32/36/40.
// - Top-level granule: 4KB, 64KB, 16KB.
// - Top-level control fields reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "s2tc_consts.svh"
module s2tc_top #(
	parameter int unsigned NUM_DOMAINS = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic sr_req_i,
	input wire logic sr_write_i,
	input wire logic [1:0] sr_sel_i,
	input wire logic [1:0] sr_el_i,
	input wire logic [63:0] sr_wdata_i,
	output logic sr_ack_o,
	output logic sr_trap_o,
	output logic [63:0] sr_rdata_o,
	output logic [5:0] s2_pa_bits_o,
	output logic [1:0] s2_granule_o,
	output logic [1:0] s2_share_o,
	output logic [1:0] s2_outer_o,
	output logic [1:0] s2_inner_o,
	output logic [1:0] s2_start_level_o,
	output logic [5:0] s2_size_offset_o,
	output logic s2_cfg_illegal_o,
	output logic s2_ctrl_changed_o,
	output logic tl_top_byte_ignore_o,
	output logic [5:0] tl_pa_bits_o,
	output logic [1:0] tl_granule_o,
	output logic [1:0] tl_share_o,
	output logic [1:0] tl_outer_o,
	output logic [1:0] tl_inner_o,
	output logic [5:0] tl_size_offset_o,
	output logic tl_cfg_illegal_o,
	output logic [47:0] tl_walk_base_o,
	output logic [5:0] tl_align_bits_o,
	input wire logic dom_req_i,
	input wire logic [3:0] dom_index_i,
	input wire logic dom_state32_i,
	input wire logic dom_perm_ok_i,
	output logic dom_valid_o,
	output logic dom_fault_o,
	output logic dom_perm_fault_o,
	output logic dom_pass_o
);
	if (NUM_DOMAINS != 16)
	begin : g_domain_count_check
		$error("NUM_DOMAINS must be 16 to fill the 32-bit domain register.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and access decode.

	logic [31:0] s2_ctrl_reg;
	logic [31:0] dom_reg;
	logic [47:0] base_reg;
	logic [31:0] tl_ctrl_reg;
	logic allowed;
	logic wr_ok;
	logic [31:0] s2_ctrl_view;
	logic [31:0] tl_ctrl_view;
	logic [63:0] rdata_next;

	always_comb
	begin
		unique case (sr_sel_i)
			`S2TC_SEL_S2CTRL: allowed = sr_el_i >= `S2TC_EL_HYP;
			`S2TC_SEL_DOMAIN: allowed = sr_el_i >= `S2TC_EL_HYP;
			`S2TC_SEL_TLBASE: allowed = sr_el_i == `S2TC_EL_TOP;
			`S2TC_SEL_TLCTRL: allowed = sr_el_i == `S2TC_EL_TOP;
		endcase
	end

	assign wr_ok = sr_req_i && sr_write_i && allowed;

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s2_ctrl_reg <= `S2TC_S2_RST;
		else if (wr_ok && sr_sel_i == `S2TC_SEL_S2CTRL)
			s2_ctrl_reg <= sr_wdata_i[31:0] & `S2TC_S2_WMASK;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dom_reg <= `S2TC_DOM_RST;
		else if (wr_ok && sr_sel_i == `S2TC_SEL_DOMAIN)
			dom_reg <= sr_wdata_i[31:0];
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			base_reg <= `S2TC_BASE_RST;
		else if (wr_ok && sr_sel_i == `S2TC_SEL_TLBASE)
			base_reg <= sr_wdata_i[47:0];
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tl_ctrl_reg <= `S2TC_TL_RST;
		else if (wr_ok && sr_sel_i == `S2TC_SEL_TLCTRL)
			tl_ctrl_reg <= sr_wdata_i[31:0] & `S2TC_TL_WMASK;
	end

	assign s2_ctrl_view = (s2_ctrl_reg & `S2TC_S2_WMASK) | `S2TC_S2_RES1;
	assign tl_ctrl_view = (tl_ctrl_reg & `S2TC_TL_WMASK) | `S2TC_TL_RES1;

	always_comb
	begin
		unique case (sr_sel_i)
			`S2TC_SEL_S2CTRL: rdata_next = {32'h00000000, s2_ctrl_view};
			`S2TC_SEL_DOMAIN: rdata_next = {32'h00000000, dom_reg};
			`S2TC_SEL_TLBASE: rdata_next = {16'h0000, base_reg};
			`S2TC_SEL_TLCTRL: rdata_next = {32'h00000000, tl_ctrl_view};
		endcase
	end

	// A refused access answers with zero data so no state leaks to a lower level.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sr_ack_o <= 1'b0;
			sr_trap_o <= 1'b0;
			sr_rdata_o <= 64'h0000000000000000;
		end
		else
		begin
			sr_ack_o <= sr_req_i;
			sr_trap_o <= sr_req_i && !allowed;
			if (sr_req_i && !sr_write_i && allowed)
				sr_rdata_o <= rdata_next;
			else if (sr_req_i)
				sr_rdata_o <= 64'h0000000000000000;
		end
	end

	// The walker keeps its own cached copies; this pulse is a hint for it only.
	// Change event for TLB.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s2_ctrl_changed_o <= 1'b0;
		else
			s2_ctrl_changed_o <= wr_ok && sr_sel_i == `S2TC_SEL_S2CTRL;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field decode toward the walker.

	function automatic logic [5:0] pa_bits(input logic [2:0] code);
		unique case (code)
			3'h1: pa_bits = `S2TC_PA_BITS_36;
			3'h2: pa_bits = `S2TC_PA_BITS_40;
			default: pa_bits = `S2TC_PA_BITS_32;
		endcase
	endfunction

	assign s2_pa_bits_o = pa_bits(s2_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO]);
	assign s2_granule_o = s2_ctrl_reg[`S2TC_TG_HI:`S2TC_TG_LO];
	assign s2_share_o = s2_ctrl_reg[`S2TC_SH_HI:`S2TC_SH_LO];
	assign s2_outer_o = s2_ctrl_reg[`S2TC_OC_HI:`S2TC_OC_LO];
	assign s2_inner_o = s2_ctrl_reg[`S2TC_IC_HI:`S2TC_IC_LO];
	assign s2_start_level_o = s2_ctrl_reg[`S2TC_SL_HI:`S2TC_SL_LO];
	assign s2_size_offset_o = s2_ctrl_reg[`S2TC_SZ_HI:`S2TC_SZ_LO];

	// Reserved and unsupported codes are flagged so the walker can fault instead of guessing.
	// Only 4KB and 64KB.
	assign s2_cfg_illegal_o = (s2_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO] > `S2TC_PA_CODE_MAX)
		|| (s2_granule_o != s2tc_pkg::S2TC_GR_4K && s2_granule_o != s2tc_pkg::S2TC_GR_64K)
		|| (s2_share_o == s2tc_pkg::S2TC_SH_RSVD);

	assign tl_top_byte_ignore_o = tl_ctrl_reg[`S2TC_TBI_BIT];
	assign tl_pa_bits_o = pa_bits(tl_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO]);
	assign tl_granule_o = tl_ctrl_reg[`S2TC_TG_HI:`S2TC_TG_LO];
	assign tl_share_o = tl_ctrl_reg[`S2TC_SH_HI:`S2TC_SH_LO];
	assign tl_outer_o = tl_ctrl_reg[`S2TC_OC_HI:`S2TC_OC_LO];
	assign tl_inner_o = tl_ctrl_reg[`S2TC_IC_HI:`S2TC_IC_LO];
	assign tl_size_offset_o = tl_ctrl_reg[`S2TC_SZ_HI:`S2TC_SZ_LO];

	assign tl_cfg_illegal_o = (tl_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO] > `S2TC_PA_CODE_MAX)
		|| (tl_granule_o == s2tc_pkg::S2TC_GR_RSVD)
		|| (tl_share_o == s2tc_pkg::S2TC_SH_RSVD);

	////////////////////////////////////////////////////////////////////////////////
	// Base alignment and domain check.

	s2tc_base_align u_base_align (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.base_i(base_reg),
		.size_offset_i(tl_size_offset_o),
		.granule_i(tl_granule_o),
		.walk_base_o(tl_walk_base_o),
		.align_bits_o(tl_align_bits_o)
	);

	s2tc_domain_check #(
		.NUM_DOMAINS(NUM_DOMAINS)
	) u_domain_check (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.dom_reg_i(dom_reg),
		.chk_req_i(dom_req_i),
		.chk_domain_i(dom_index_i),
		.chk_state32_i(dom_state32_i),
		.chk_perm_ok_i(dom_perm_ok_i),
		.chk_valid_o(dom_valid_o),
		.chk_domain_fault_o(dom_fault_o),
		.chk_perm_fault_o(dom_perm_fault_o),
		.chk_pass_o(dom_pass_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [47:0] wdata_low;
	assign wdata_low = sr_wdata_i[47:0];

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_top_level_priv: assert property (
		sr_req_i && sr_el_i != `S2TC_EL_TOP && sr_sel_i[1]
		|=> sr_ack_o && sr_trap_o && sr_rdata_o == 64'h0000000000000000)
		else $error("Top-level register reached below top privilege.");
	a_hyp_level_priv: assert property (
		sr_req_i && sr_el_i < `S2TC_EL_HYP && !sr_sel_i[1] |=> sr_trap_o)
		else $error("Stage 2 register reached below hypervisor privilege.");
	a_reserved_read: assert property (
		sr_req_i && !sr_write_i && sr_el_i == `S2TC_EL_TOP && sr_sel_i == `S2TC_SEL_TLCTRL
		|=> sr_rdata_o[31] && sr_rdata_o[23] && sr_rdata_o[22:21] == 2'h0
		&& sr_rdata_o[19] == 1'b0 && sr_rdata_o[7:6] == 2'h0)
		else $error("Reserved control bits read wrong.");
	a_base_readback: assert property (
		sr_req_i && sr_write_i && sr_el_i == `S2TC_EL_TOP && sr_sel_i == `S2TC_SEL_TLBASE
		##1 !sr_req_i
		##1 sr_req_i && !sr_write_i && sr_el_i == `S2TC_EL_TOP
		&& sr_sel_i == `S2TC_SEL_TLBASE
		|=> sr_rdata_o == {16'h0000, $past(wdata_low, 3)})
		else $error("Base register did not read back as written.");
	a_s2_change_pulse: assert property (
		wr_ok && sr_sel_i == `S2TC_SEL_S2CTRL
		|=> s2_ctrl_changed_o && s2_ctrl_reg == ($past(sr_wdata_i[31:0]) & `S2TC_S2_WMASK))
		else $error("Stage 2 write gave no change pulse.");
	a_s2_pa_decode: assert property (
		s2_ctrl_reg[18:16] == 3'h1 |-> s2_pa_bits_o == 6'h24 && !s2_cfg_illegal_o
		|| s2_granule_o[1] || s2_share_o == 2'h1)
		else $error("Stage 2 size code 001 not decoded as 36 bits.");
	a_tl_granule_16k: assert property (
		tl_granule_o == 2'h2 && tl_ctrl_reg[18:16] <= 3'h2 && tl_share_o != 2'h1
		|-> !tl_cfg_illegal_o)
		else $error("16KB top-level granule refused.");

	// Refused writes must leave every register as it was, so a lower level cannot plant state.
	a_write_answered: assert property (
		sr_req_i |=> sr_ack_o)
		else $error("Register access was not answered.");
	a_hyp_write_gate: assert property (
		sr_req_i && sr_write_i && sr_el_i < `S2TC_EL_HYP
		|=> s2_ctrl_reg == $past(s2_ctrl_reg) && dom_reg == $past(dom_reg))
		else $error("Refused write changed a stage 2 register.");
	a_top_write_gate: assert property (
		sr_req_i && sr_write_i && sr_el_i != `S2TC_EL_TOP
		|=> base_reg == $past(base_reg) && tl_ctrl_reg == $past(tl_ctrl_reg))
		else $error("Refused write changed a top-level register.");
	a_base_upper_zero: assert property (
		sr_req_i && !sr_write_i && sr_el_i == `S2TC_EL_TOP && sr_sel_i == `S2TC_SEL_TLBASE
		|=> sr_rdata_o[63:48] == 16'h0000)
		else $error("Base register upper bits read nonzero.");
	a_s2_change_only: assert property (
		!(wr_ok && sr_sel_i == `S2TC_SEL_S2CTRL) |=> !s2_ctrl_changed_o)
		else $error("Change pulse without a stage 2 write.");
	a_s2_pa_reserved: assert property (
		s2_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO] > `S2TC_PA_CODE_MAX
		|-> s2_cfg_illegal_o && s2_pa_bits_o == `S2TC_PA_BITS_32)
		else $error("Reserved stage 2 size code not flagged.");
	a_s2_granule_rsvd: assert property (
		s2_granule_o[1] |-> s2_cfg_illegal_o)
		else $error("Unsupported stage 2 granule not flagged.");
	a_s2_share_rsvd: assert property (
		s2_share_o == s2tc_pkg::S2TC_SH_RSVD |-> s2_cfg_illegal_o)
		else $error("Reserved stage 2 shareability not flagged.");
	a_tl_pa_decode: assert property (
		tl_ctrl_reg[`S2TC_PS_HI:`S2TC_PS_LO] == 3'h2 |-> tl_pa_bits_o == `S2TC_PA_BITS_40)
		else $error("Top-level size code 010 not decoded as 40 bits.");
	a_tl_share_rsvd: assert property (
		tl_share_o == s2tc_pkg::S2TC_SH_RSVD |-> tl_cfg_illegal_o)
		else $error("Reserved top-level shareability not flagged.");
	a_tl_granule_rsvd: assert property (
		tl_granule_o == s2tc_pkg::S2TC_GR_RSVD |-> tl_cfg_illegal_o)
		else $error("Unsupported top-level granule not flagged.");
endmodule
`default_nettype wire

// ===== shared/s2tc_consts.svh
// Offsets, field positions, reset values and masks of the translation control bank.
`ifndef S2TC_CONSTS_SVH
`define S2TC_CONSTS_SVH
`define S2TC_SEL_S2CTRL 2'h0
`define S2TC_SEL_DOMAIN 2'h1
`define S2TC_SEL_TLBASE 2'h2
`define S2TC_SEL_TLCTRL 2'h3
`define S2TC_EL_HYP 2'h2
`define S2TC_EL_TOP 2'h3
`define S2TC_TBI_BIT 20
`define S2TC_PS_HI 18
`define S2TC_PS_LO 16
`define S2TC_TG_HI 15
`define S2TC_TG_LO 14
`define S2TC_SH_HI 13
`define S2TC_SH_LO 12
`define S2TC_OC_HI 11
`define S2TC_OC_LO 10
`define S2TC_IC_HI 9
`define S2TC_IC_LO 8
`define S2TC_SL_HI 7
`define S2TC_SL_LO 6
`define S2TC_SZ_HI 5
`define S2TC_SZ_LO 0
`define S2TC_S2_WMASK 32'h0007FFFF
`define S2TC_TL_WMASK 32'h0017FF3F
`define S2TC_S2_RES1 32'h80000000
`define S2TC_TL_RES1 32'h80800000
`define S2TC_S2_RST 32'h00000000
`define S2TC_TL_RST 32'h00000000
`define S2TC_DOM_RST 32'h00000000
`define S2TC_BASE_RST 48'h000000000000
`define S2TC_BASE_W 48
`define S2TC_PA_CODE_MAX 3'h2
`define S2TC_PA_BITS_32 6'h20
`define S2TC_PA_BITS_36 6'h24
`define S2TC_PA_BITS_40 6'h28
`endif

// ===== shared/s2tc_pkg.sv
// Types shared by the translation control bank.
package s2tc_pkg;
	typedef enum logic [1:0] {
		S2TC_GR_4K = 2'h0,
		S2TC_GR_64K = 2'h1,
		S2TC_GR_16K = 2'h2,
		S2TC_GR_RSVD = 2'h3
	} s2tc_granule_e;
	typedef enum logic [1:0] {
		S2TC_SH_NON = 2'h0,
		S2TC_SH_RSVD = 2'h1,
		S2TC_SH_OUTER = 2'h2,
		S2TC_SH_INNER = 2'h3
	} s2tc_share_e;
	typedef enum logic [1:0] {
		S2TC_DOM_NOACC = 2'h0,
		S2TC_DOM_CLIENT = 2'h1,
		S2TC_DOM_RSVD = 2'h2,
		S2TC_DOM_MANAGER = 2'h3
	} s2tc_domain_e;
	typedef logic [5:0] s2tc_size_t;
endpackage

// ===== hw/s2tc_domain_check.sv
// Domain access check for 32-bit code against the domain access register.
`timescale 1ns/1ps
`default_nettype none
module s2tc_domain_check #(
	parameter int unsigned NUM_DOMAINS = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [2*NUM_DOMAINS-1:0] dom_reg_i,
	input wire logic chk_req_i,
	input wire logic [$clog2(NUM_DOMAINS)-1:0] chk_domain_i,
	input wire logic chk_state32_i,
	input wire logic chk_perm_ok_i,
	output logic chk_valid_o,
	output logic chk_domain_fault_o,
	output logic chk_perm_fault_o,
	output logic chk_pass_o
);
	s2tc_pkg::s2tc_domain_e code;
	logic dom_fault_next;
	logic perm_fault_next;

	assign code = s2tc_pkg::s2tc_domain_e'(dom_reg_i[2*chk_domain_i +: 2]);

	always_comb
	begin
		dom_fault_next = 1'b0;
		perm_fault_next = !chk_perm_ok_i;
		if (chk_state32_i)
		begin
			unique case (code)
				s2tc_pkg::S2TC_DOM_NOACC:
				begin
					dom_fault_next = 1'b1;
					perm_fault_next = 1'b0;
				end
				s2tc_pkg::S2TC_DOM_CLIENT: perm_fault_next = !chk_perm_ok_i;
				s2tc_pkg::S2TC_DOM_MANAGER: perm_fault_next = 1'b0;
				// The reserved code is treated like client, the safer reading.
				s2tc_pkg::S2TC_DOM_RSVD: perm_fault_next = !chk_perm_ok_i;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chk_valid_o <= 1'b0;
			chk_domain_fault_o <= 1'b0;
			chk_perm_fault_o <= 1'b0;
			chk_pass_o <= 1'b0;
		end
		else
		begin
			chk_valid_o <= chk_req_i;
			chk_domain_fault_o <= chk_req_i && dom_fault_next;
			chk_perm_fault_o <= chk_req_i && perm_fault_next;
			chk_pass_o <= chk_req_i && !dom_fault_next && !perm_fault_next;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_domain_noacc_fault: assert property (
		chk_req_i && chk_state32_i && code == s2tc_pkg::S2TC_DOM_NOACC
		|=> chk_domain_fault_o && !chk_pass_o)
		else $error("No-access domain did not fault.");
	a_domain_client_check: assert property (
		chk_req_i && chk_state32_i && code == s2tc_pkg::S2TC_DOM_CLIENT
		|=> chk_perm_fault_o == !$past(chk_perm_ok_i))
		else $error("Client domain ignored table permissions.");
	a_domain_manager_pass: assert property (
		chk_req_i && chk_state32_i && code == s2tc_pkg::S2TC_DOM_MANAGER
		|=> chk_pass_o && !chk_perm_fault_o)
		else $error("Manager domain was checked.");
	a_wide_state_ignore: assert property (
		chk_req_i && !chk_state32_i |=> !chk_domain_fault_o)
		else $error("Domain fault raised in the wide state.");
endmodule
`default_nettype wire

// ===== hw/s2tc_base_align.sv
// Works out the table alignment and hands the walker a base with low bits cleared.
`timescale 1ns/1ps
`default_nettype none
`include "s2tc_consts.svh"
module s2tc_base_align (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [`S2TC_BASE_W-1:0] base_i,
	input wire s2tc_pkg::s2tc_size_t size_offset_i,
	input wire logic [1:0] granule_i,
	output logic [`S2TC_BASE_W-1:0] walk_base_o,
	output logic [5:0] align_bits_o
);
	logic [6:0] va_bits;
	logic [6:0] page_bits;
	logic [6:0] stride;
	logic [6:0] top_bits;
	logic [6:0] x_full;
	logic [`S2TC_BASE_W-1:0] low_mask;

	// Out-of-range offsets are clamped so the alignment stays within the base field.
	always_comb
	begin
		va_bits = 7'h40 - {1'b0, size_offset_i};
		if (va_bits > 7'h30)
			va_bits = 7'h30;
		unique case (s2tc_pkg::s2tc_granule_e'(granule_i))
			s2tc_pkg::S2TC_GR_64K: page_bits = 7'h10;
			s2tc_pkg::S2TC_GR_16K: page_bits = 7'h0E;
			default: page_bits = 7'h0C;
		endcase
		if (va_bits <= page_bits)
			va_bits = page_bits + 7'h01;
		stride = page_bits - 7'h03;
		top_bits = ((va_bits - page_bits - 7'h01) % stride) + 7'h01;
		x_full = top_bits + 7'h03;
		low_mask = (48'h000000000001 << x_full) - 48'h000000000001;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			walk_base_o <= `S2TC_BASE_RST;
			align_bits_o <= 6'h00;
		end
		else
		begin
			walk_base_o <= base_i & ~low_mask;
			align_bits_o <= x_full[5:0];
		end
	end

	logic [`S2TC_BASE_W-1:0] out_mask;
	assign out_mask = (48'h000000000001 << align_bits_o) - 48'h000000000001;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_walk_base_low: assert property (
		(walk_base_o & out_mask) == 48'h000000000000)
		else $error("Walker base has low bits set.");
	a_walk_base_high: assert property (
		##1 (walk_base_o & ~out_mask) == ($past(base_i) & ~out_mask))
		else $error("Walker base upper bits differ from register.");
endmodule
`default_nettype wire

// ===== tb/s2tc_top_tb.sv
// Self-checking bench for the translation control register bank.
`timescale 1ns/1ps
`default_nettype none
`include "s2tc_consts.svh"
module s2tc_top_tb;
	logic ref_clk_i;
	logic rst_n_i;
	logic sr_req_i;
	logic sr_write_i;
	logic [1:0] sr_sel_i;
	logic [1:0] sr_el_i;
	logic [63:0] sr_wdata_i;
	logic sr_ack_o, sr_trap_o, s2_cfg_illegal_o, s2_ctrl_changed_o, tl_top_byte_ignore_o;
	logic tl_cfg_illegal_o, dom_valid_o, dom_fault_o, dom_perm_fault_o, dom_pass_o;
	logic [63:0] sr_rdata_o;
	logic [5:0] s2_pa_bits_o, s2_size_offset_o, tl_pa_bits_o, tl_size_offset_o, tl_align_bits_o;
	logic [1:0] s2_granule_o, s2_share_o, s2_outer_o, s2_inner_o, s2_start_level_o;
	logic [1:0] tl_granule_o, tl_share_o, tl_outer_o, tl_inner_o;
	logic [47:0] tl_walk_base_o;
	logic dom_req_i;
	logic [3:0] dom_index_i;
	logic dom_state32_i;
	logic dom_perm_ok_i;
	int n_errors;
	int num_checks;
	int cycles;

	s2tc_top s2tc_top_i (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sr_req_i(sr_req_i),
		.sr_write_i(sr_write_i), .sr_sel_i(sr_sel_i), .sr_el_i(sr_el_i),
		.sr_wdata_i(sr_wdata_i), .sr_ack_o(sr_ack_o), .sr_trap_o(sr_trap_o),
		.sr_rdata_o(sr_rdata_o), .s2_pa_bits_o(s2_pa_bits_o), .s2_granule_o(s2_granule_o),
		.s2_share_o(s2_share_o), .s2_outer_o(s2_outer_o), .s2_inner_o(s2_inner_o),
		.s2_start_level_o(s2_start_level_o), .s2_size_offset_o(s2_size_offset_o),
		.s2_cfg_illegal_o(s2_cfg_illegal_o), .s2_ctrl_changed_o(s2_ctrl_changed_o),
		.tl_top_byte_ignore_o(tl_top_byte_ignore_o), .tl_pa_bits_o(tl_pa_bits_o),
		.tl_granule_o(tl_granule_o), .tl_share_o(tl_share_o), .tl_outer_o(tl_outer_o),
		.tl_inner_o(tl_inner_o), .tl_size_offset_o(tl_size_offset_o),
		.tl_cfg_illegal_o(tl_cfg_illegal_o), .tl_walk_base_o(tl_walk_base_o),
		.tl_align_bits_o(tl_align_bits_o), .dom_req_i(dom_req_i), .dom_index_i(dom_index_i),
		.dom_state32_i(dom_state32_i), .dom_perm_ok_i(dom_perm_ok_i),
		.dom_valid_o(dom_valid_o), .dom_fault_o(dom_fault_o),
		.dom_perm_fault_o(dom_perm_fault_o), .dom_pass_o(dom_pass_o)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The answer pulse stands one cycle, so it is looked at just after the edge it lands on.
	task automatic access(input logic wr, input logic [1:0] sel, input logic [1:0] el,
		input logic [63:0] wd, input logic exp_trap, input logic [63:0] exp_rd, input string what);
		@(posedge ref_clk_i);
		sr_req_i <= 1'b1;
		sr_write_i <= wr;
		sr_sel_i <= sel;
		sr_el_i <= el;
		sr_wdata_i <= wd;
		@(posedge ref_clk_i);
		sr_req_i <= 1'b0;
		#1;
		chk({what, " ack"}, 64'h1, 64'(sr_ack_o));
		chk({what, " trap"}, 64'(exp_trap), 64'(sr_trap_o));
		chk({what, " rdata"}, exp_rd, sr_rdata_o);
	endtask

	task automatic wr2(input logic [63:0] v);
		access(1'b1, `S2TC_SEL_S2CTRL, `S2TC_EL_HYP, v, 1'b0, 64'h0, "s2 write");
		chk("s2_ctrl_changed_o", 64'h1, 64'(s2_ctrl_changed_o));
		access(1'b1, `S2TC_SEL_TLCTRL, `S2TC_EL_TOP, v, 1'b0, 64'h0, "tl write");
		chk("s2_ctrl_changed_o", 64'h0, 64'(s2_ctrl_changed_o));
	endtask

	task automatic dom_chk(input int idx, input logic s32, input logic pok, input logic [2:0] exp);
		@(posedge ref_clk_i);
		dom_req_i <= 1'b1;
		dom_index_i <= 4'(idx);
		dom_state32_i <= s32;
		dom_perm_ok_i <= pok;
		@(posedge ref_clk_i);
		dom_req_i <= 1'b0;
		#1;
		chk("dom result", 64'({1'b1, exp}),
			64'({dom_valid_o, dom_fault_o, dom_perm_fault_o, dom_pass_o}));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [63:0] rv [4];
		logic [63:0] v;
		logic [5:0] pa;
		logic [1:0] code;
		logic t;
		int xs [3];
		logic [63:0] tv [3];
		rv = '{64'h80000000, 64'h0, 64'h0, 64'h80800000};
		xs = '{12, 5, 9};
		tv = '{64'h0, 64'h20, 64'h4010};
		n_errors = 0;
		num_checks = 0;
		cycles = 0;
		rst_n_i = 1'b0;
		sr_req_i = 1'b0;
		sr_write_i = 1'b0;
		sr_sel_i = 2'h0;
		sr_el_i = 2'h0;
		sr_wdata_i = 64'h0;
		dom_req_i = 1'b0;
		dom_index_i = 4'h0;
		dom_state32_i = 1'b0;
		dom_perm_ok_i = 1'b0;
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int s = 0; s < 4; s++)
			for (int e = 0; e < 4; e++)
			begin
				t = (s < 2) ? (e < 2) : (e != 3);
				access(1'b0, 2'(s), 2'(e), 64'h0, t, t ? 64'h0 : rv[s], "read");
			end
		access(1'b1, `S2TC_SEL_S2CTRL, 2'h1, '1, 1'b1, 64'h0, "low write");
		access(1'b1, `S2TC_SEL_TLCTRL, `S2TC_EL_HYP, '1, 1'b1, 64'h0, "hyp write");
		access(1'b0, `S2TC_SEL_S2CTRL, `S2TC_EL_HYP, 0, 1'b0, rv[0], "s2 kept");
		access(1'b0, `S2TC_SEL_TLCTRL, `S2TC_EL_TOP, 0, 1'b0, rv[3], "tl kept");
		chk("tl_pa_bits_o", 64'h20, 64'(tl_pa_bits_o));
		wr2('1);
		access(1'b0, `S2TC_SEL_S2CTRL, `S2TC_EL_TOP, 0, 1'b0, 64'h8007FFFF, "s2 ones");
		access(1'b0, `S2TC_SEL_TLCTRL, `S2TC_EL_TOP, 0, 1'b0, 64'h8097FF3F, "tl ones");
		for (int c = 0; c < 8; c++)
		begin
			wr2(64'(c) << 16);
			pa = (c == 1) ? 6'h24 : ((c == 2) ? 6'h28 : 6'h20);
			chk("s2_pa_bits_o", 64'(pa), 64'(s2_pa_bits_o));
			chk("tl_pa_bits_o", 64'(pa), 64'(tl_pa_bits_o));
			chk("s2_cfg_illegal_o", 64'(c > 2), 64'(s2_cfg_illegal_o));
		end
		for (int c = 0; c < 4; c++)
		begin
			wr2(64'(c) << 14);
			chk("s2_granule_o", 64'(c), 64'(s2_granule_o));
			chk("tl_granule_o", 64'(c), 64'(tl_granule_o));
			chk("s2_cfg_illegal_o", 64'(c > 1), 64'(s2_cfg_illegal_o));
			chk("tl_cfg_illegal_o", 64'(c == 3), 64'(tl_cfg_illegal_o));
			wr2(64'(c) << 12);
			chk("s2_share_o", 64'(c), 64'(s2_share_o));
			chk("tl_share_o", 64'(c), 64'(tl_share_o));
			chk("tl_cfg_illegal_o", 64'(c == 1), 64'(tl_cfg_illegal_o));
			v = (64'(c & 1) << 20) | (64'(c) << 10) | (64'(3 - c) << 8) | (64'(c) << 6) | 64'(c * 21);
			wr2(v);
			chk("s2_outer_o", 64'(c), 64'(s2_outer_o));
			chk("tl_outer_o", 64'(c), 64'(tl_outer_o));
			chk("s2_inner_o", 64'(3 - c), 64'(s2_inner_o));
			chk("tl_inner_o", 64'(3 - c), 64'(tl_inner_o));
			chk("s2_start_level_o", 64'(c), 64'(s2_start_level_o));
			chk("s2_size_offset_o", 64'(c * 21), 64'(s2_size_offset_o));
			chk("tl_size_offset_o", 64'(c * 21), 64'(tl_size_offset_o));
			chk("tl_top_byte_ignore_o", 64'(c & 1), 64'(tl_top_byte_ignore_o));
			access(1'b0, 0, 3, 0, 1'b0, (v & 64'h7FFFF) | 64'h80000000, "s2 back");
			access(1'b0, 3, 3, 0, 1'b0, (v & 64'h17FF3F) | 64'h80800000, "tl back");
		end
		// Domain codes 0, 1, 1, 3 per byte; the reserved code is never written.
		access(1'b1, 1, 2, 64'hD4D4D4D4, 1'b0, 64'h0, "dom write");
		access(1'b0, `S2TC_SEL_DOMAIN, `S2TC_EL_TOP, 0, 1'b0, 64'hD4D4D4D4, "dom back");
		for (int n = 0; n < 16; n++)
			for (int p = 0; p < 2; p++)
			begin
				code = (n % 4 == 0) ? 2'h0 : ((n % 4 == 3) ? 2'h3 : 2'h1);
				if (code == 2'h0)
					dom_chk(n, 1'b1, p[0], 3'h4);
				else if (code == 2'h3)
					dom_chk(n, 1'b1, p[0], 3'h1);
				else
					dom_chk(n, 1'b1, p[0], p[0] ? 3'h1 : 3'h2);
				dom_chk(n, 1'b0, p[0], p[0] ? 3'h1 : 3'h2);
			end
		access(1'b1, `S2TC_SEL_TLBASE, `S2TC_EL_TOP, '1, 1'b0, 64'h0, "base write");
		access(1'b0, 2, 3, 0, 1'b0, 64'h0000FFFFFFFFFFFF, "base back");
		for (int k = 0; k < 3; k++)
		begin
			access(1'b1, 3, 3, tv[k], 1'b0, 64'h0, "tl size");
			repeat (2) @(posedge ref_clk_i);
			#1;
			chk("tl_align_bits_o", 64'(xs[k]), 64'(tl_align_bits_o));
			v = 64'hFFFFFFFFFFFF & ~((64'h1 << xs[k]) - 64'h1);
			chk("tl_walk_base_o", v, 64'(tl_walk_base_o));
			access(1'b0, 2, 3, 0, 1'b0, 64'h0000FFFFFFFFFFFF, "base low");
		end
		// A base aligned by software reaches the walker unchanged.
		access(1'b1, 2, 3, 64'h0000ABCDEF123000, 1'b0, 64'h0, "base aligned");
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("tl_walk_base_o", 64'h0000ABCDEF123000, 64'(tl_walk_base_o));
		// A second reset in mid-run must bring every written top-level control field back to zero.
		wr2('1);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		access(1'b0, 3, 3, 0, 1'b0, 64'h80800000, "tl rerun");
		chk("tl_top_byte_ignore_o", 64'h0, 64'(tl_top_byte_ignore_o));
		chk("tl_walk_base_o", 64'h0, 64'(tl_walk_base_o));
		complete_run();
	end
endmodule
`default_nettype wire
